// ===== hw/acq_pkg.sv
package acq_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned NO_SIGNAL_MS     = 250;
   localparam longint unsigned NO_SIGNAL_CYC = longint'(NO_SIGNAL_MS) * 1000 * CLK_MHZ;
   localparam int unsigned TIMER_W          = 27;

   // ---------------------------------------------------------------
   // Field widths and encodings
   // ---------------------------------------------------------------
   localparam int unsigned FFT_W  = 3;
   localparam int unsigned GI_W   = 3;
   localparam int unsigned IDX_W  = 8;
   localparam int unsigned SYM_W  = 4;
   localparam logic [2:0] FFT_1K  = 3'h0;
   localparam logic [2:0] FFT_2K  = 3'h1;
   localparam logic [2:0] FFT_4K  = 3'h2;
   localparam logic [2:0] FFT_8K  = 3'h3;
   localparam logic [2:0] FFT_16K = 3'h4;
   localparam logic [2:0] FFT_32K = 3'h5;
   localparam logic [3:0] PILOT_STEP_DENSE  = 4'h3;
   localparam logic [3:0] PILOT_STEP_SPARSE = 4'h6;

   typedef enum logic [3:0] {
      ST_IDLE, ST_SEARCH, ST_CAPTURE, ST_DECODE, ST_VERIFY, ST_LOCATE,
      ST_WAIT_PIPE, ST_RUN, ST_RETUNE
   } acq_state_e;

   // Number of second-preamble symbols fixed by FFT size
   function automatic logic [3:0] p2_count(input logic [2:0] fft);
      case (fft)
         FFT_1K:  p2_count = 4'h0; // Sixteen: counter wraps to zero
         FFT_2K:  p2_count = 4'h8;
         FFT_4K:  p2_count = 4'h4;
         FFT_8K:  p2_count = 4'h2;
         FFT_16K: p2_count = 4'h1;
         FFT_32K: p2_count = 4'h1;
         default: p2_count = 4'h1;
      endcase
   endfunction
endpackage

// ===== hw/acq_params_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acq_params_if;
   logic [2:0] fft_size;
   logic       single_antenna_mode;
   logic [2:0] guard_interval;
   logic       load;
   logic       mismatch;
   modport keeper (input load, output fft_size, single_antenna_mode, guard_interval,
                   output mismatch);
   modport user   (output load, input fft_size, single_antenna_mode, guard_interval,
                   input mismatch);
endinterface
`default_nettype wire

// ===== hw/acq_param_store.sv
`timescale 1ns/1ps
`default_nettype none
module acq_param_store
   import acq_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [2:0] new_fft,
   input  wire logic       new_single_antenna,
   input  wire logic [2:0] new_gi,
   input  wire logic [2:0] sig_fft,
   input  wire logic       sig_single_antenna,
   input  wire logic [2:0] sig_gi,
   acq_params_if.keeper    prm
);
   logic [2:0] fft_q, fft_d;
   logic       sa_q, sa_d;
   logic [2:0] gi_q, gi_d;

   // ---------------------------------------------------------------
   // Stored basic parameters, kept across visits
   // ---------------------------------------------------------------
   always_comb begin
      fft_d = fft_q;
      sa_d  = sa_q;
      gi_d  = gi_q;
      if (prm.load) begin
         fft_d = new_fft;
         sa_d  = new_single_antenna;
         gi_d  = new_gi;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fft_q <= FFT_8K;
         sa_q  <= 1'b1;
         gi_q  <= 3'h0;
      end else begin
         fft_q <= fft_d;
         sa_q  <= sa_d;
         gi_q  <= gi_d;
      end
   end

   assign prm.fft_size            = fft_q;
   assign prm.single_antenna_mode = sa_q;
   assign prm.guard_interval      = gi_q;
   // Repeated values must match what decode used
   assign prm.mismatch = (sig_fft != fft_q) || (sig_single_antenna != sa_q) || (sig_gi != gi_q);
endmodule
`default_nettype wire

// ===== hw/acq_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Decode preamble with FFT, antenna, guard only
// - Second preamble follows first, count from FFT
// - Buffer all second symbols before decoding
// - Pilot every third carrier, sixth 32K single
// - Start normal carriers on scan, switch if extended signalled
// - Check repeated parameters against those used
// - First preamble marks frame or extension start
// - Frame position from current frame index
// - Index, interval, length locate extension parts
// - Index needed for multi-frame or skipping pipes
// - Signalling decode needs no frame index
// - Channel change redoes sync, may seed stored
// - Frame-start search may run during resync
// - Channel change may reuse stored parameters
// - Multi-frame pipe waits next interleaving start
// - Short-interleaved pipe starts next frame
// - Locate pipe cells from dynamic signalling
// - No signal if no preamble in 250 ms
module acq_seq
   import acq_pkg::*;
#(
   parameter longint unsigned NO_SIGNAL_CYCLES = NO_SIGNAL_CYC
)(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             start_scan,
   input  wire logic             start_zap,
   input  wire logic             tuner_settled,
   input  wire logic             seed_from_store,
   input  wire logic             sync_done,
   input  wire logic             preamble_seen,
   input  wire logic             preamble_is_extension,
   input  wire logic [2:0]       det_fft_size,
   input  wire logic             det_single_antenna,
   input  wire logic [2:0]       det_guard_interval,
   input  wire logic             symbol_strobe,
   input  wire logic             decode_done,
   input  wire logic             decode_ok,
   input  wire logic [2:0]       sig_fft_size,
   input  wire logic             sig_single_antenna,
   input  wire logic [2:0]       sig_guard_interval,
   input  wire logic             sig_extended_carriers,
   input  wire logic [7:0]       current_frame_index,
   input  wire logic [7:0]       extension_part_interval,
   input  wire logic [7:0]       extension_part_length,
   input  wire logic [7:0]       pipe_frame_interval,
   input  wire logic [7:0]       pipe_first_frame_index,
   input  wire logic [7:0]       interleaving_length,
   input  wire logic             interleaving_type,
   input  wire logic             cells_valid,
   output logic [3:0]            state_out,
   output logic                  no_signal,
   output logic                  acquired,
   output logic                  run_sync,
   output logic                  use_seed,
   output logic                  capture_enable,
   output logic                  decode_start,
   output logic [2:0]            dec_fft_size,
   output logic                  dec_single_antenna,
   output logic [2:0]            dec_guard_interval,
   output logic [3:0]            pilot_step,
   output logic                  extended_carriers,
   output logic [7:0]            frame_position,
   output logic                  extension_part_active,
   output logic                  pipe_enable,
   output logic                  pipe_cells_load
);
   // ---------------------------------------------------------------
   // Shared parameter store
   // ---------------------------------------------------------------
   acq_params_if prm ();

   acq_param_store u_store (
      .clk_sys            (clk_sys),
      .rst                (rst),
      .new_fft            (det_fft_size),
      .new_single_antenna (det_single_antenna),
      .new_gi             (det_guard_interval),
      .sig_fft            (sig_fft_size),
      .sig_single_antenna (sig_single_antenna),
      .sig_gi             (sig_guard_interval),
      .prm                (prm)
   );

   acq_state_e   st_q, st_d;
   logic [26:0]  tmr_q, tmr_d;
   logic [3:0]   sym_q, sym_d;
   logic         zap_q, zap_d;
   logic         ext_q, ext_d;
   logic [7:0]   fidx_q, fidx_d;
   logic [7:0]   ext_cnt_q, ext_cnt_d;
   logic         ext_act_q, ext_act_d;
   logic         nosig_q, nosig_d;
   logic         dstart_q, dstart_d;
   logic         cells_q, cells_d;
   logic         load_d;
   logic         multi_frame;
   logic [7:0]   il_span;
   logic [7:0]   rel_idx;
   logic         pipe_start;
   logic         ext_due;

   localparam logic [26:0] TMR_LAST = 27'(NO_SIGNAL_CYCLES - 1);

   assign prm.load = load_d;

   // ---------------------------------------------------------------
   // Frame timing decode
   // ---------------------------------------------------------------
   // Multi-frame when interleaving spans frames or frames are skipped
   assign multi_frame = interleaving_type || (pipe_frame_interval > 8'h01);
   assign il_span     = interleaving_type ? 8'(pipe_frame_interval * interleaving_length)
                                          : pipe_frame_interval;
   assign rel_idx     = 8'(fidx_q - pipe_first_frame_index);
   // Next interleaving frame begins when index aligns to span
   assign pipe_start  = (il_span == 8'h00) ? 1'b1 : ((rel_idx % il_span) == 8'h00);
   // Extension parts follow every interval-th frame
   assign ext_due     = (extension_part_interval != 8'h00) &&
                        (((fidx_q + 8'h01) % extension_part_interval) == 8'h00);

   // ---------------------------------------------------------------
   // Sequencer next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d      = st_q;
      tmr_d     = tmr_q;
      sym_d     = sym_q;
      zap_d     = zap_q;
      ext_d     = ext_q;
      fidx_d    = fidx_q;
      ext_cnt_d = ext_cnt_q;
      ext_act_d = ext_act_q;
      nosig_d   = nosig_q;
      dstart_d  = 1'b0;
      cells_d   = 1'b0;
      load_d    = 1'b0;
      // Extension part ends when its length runs out
      if (ext_act_q) begin
         if (ext_cnt_q == 8'h00) begin
            ext_act_d = 1'b0;
         end else begin
            ext_cnt_d = 8'(ext_cnt_q - 8'h01);
         end
      end
      // First preamble is the time reference of every frame
      // Locate included so a preamble right after verify is not lost
      if (preamble_seen && (st_q == ST_RUN || st_q == ST_WAIT_PIPE || st_q == ST_LOCATE)) begin
         if (preamble_is_extension) begin
            // Only an extension part due by index and interval is taken
            ext_act_d = ext_due;
            ext_cnt_d = extension_part_length;
         end else begin
            ext_act_d = 1'b0;
            fidx_d    = 8'(fidx_q + 8'h01);
         end
      end
      case (st_q)
         ST_IDLE: begin
            if (start_zap) begin
               zap_d = 1'b1;
               st_d  = ST_RETUNE;
            end else if (start_scan) begin
               zap_d   = 1'b0;
               ext_d   = 1'b0;
               nosig_d = 1'b0;
               tmr_d   = '0;
               st_d    = ST_SEARCH;
            end
         end
         ST_RETUNE: begin
            tmr_d = '0;
            // Resync only after the tuner settles
            if (tuner_settled) st_d = ST_SEARCH;
         end
         ST_SEARCH: begin
            // Frame start sought while sync still converging on a channel change; a scan waits for sync_done
            if (preamble_seen && !preamble_is_extension && (sync_done || zap_q)) begin
               // Stored parameters reused on channel change
               load_d = !zap_q;
               sym_d  = '0;
               st_d   = ST_CAPTURE;
            end else if (tmr_q == TMR_LAST) begin
               nosig_d = 1'b1;
               st_d    = ST_IDLE;
            end else begin
               tmr_d = 27'(tmr_q + 27'h1);
            end
         end
         ST_CAPTURE: begin
            // All symbols held; signalling is spread over them
            if (symbol_strobe) begin
               sym_d = 4'(sym_q + 4'h1);
               if (4'(sym_q + 4'h1) == p2_count(prm.fft_size)) begin
                  dstart_d = 1'b1;
                  st_d     = ST_DECODE;
               end
            end
         end
         ST_DECODE: begin
            if (decode_done) st_d = decode_ok ? ST_VERIFY : ST_SEARCH;
            if (decode_done && !decode_ok) tmr_d = '0;
         end
         ST_VERIFY: begin
            if (prm.mismatch) begin
               tmr_d = '0;
               zap_d = 1'b0;
               st_d  = ST_SEARCH;
            end else begin
               ext_d  = sig_extended_carriers;
               fidx_d = current_frame_index;
               st_d   = ST_LOCATE;
            end
         end
         ST_LOCATE: begin
            ext_cnt_d = extension_part_length;
            st_d      = multi_frame ? ST_WAIT_PIPE : ST_RUN;
         end
         ST_WAIT_PIPE: begin
            if (pipe_start) st_d = ST_RUN;
         end
         ST_RUN: begin
            cells_d = cells_valid;
            if (start_zap) begin
               zap_d = 1'b1;
               st_d  = ST_RETUNE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q      <= ST_IDLE;
         tmr_q     <= '0;
         sym_q     <= '0;
         zap_q     <= 1'b0;
         ext_q     <= 1'b0;
         fidx_q    <= '0;
         ext_cnt_q <= '0;
         ext_act_q <= 1'b0;
         nosig_q   <= 1'b0;
         dstart_q  <= 1'b0;
         cells_q   <= 1'b0;
      end else begin
         st_q      <= st_d;
         tmr_q     <= tmr_d;
         sym_q     <= sym_d;
         zap_q     <= zap_d;
         ext_q     <= ext_d;
         fidx_q    <= fidx_d;
         ext_cnt_q <= ext_cnt_d;
         ext_act_q <= ext_act_d;
         nosig_q   <= nosig_d;
         dstart_q  <= dstart_d;
         cells_q   <= cells_d;
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   logic [3:0] state_q;
   logic       acq_q, sync_q, seed_q, cap_q, pipe_q;
   logic [2:0] dfft_q, dgi_q;
   logic       dsa_q;
   logic [3:0] step_q, step_d;

   // Sparse pilots only in 32K single-antenna
   assign step_d = (prm.fft_size == FFT_32K && prm.single_antenna_mode)
                   ? PILOT_STEP_SPARSE : PILOT_STEP_DENSE;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= '0;
         acq_q   <= 1'b0;
         sync_q  <= 1'b0;
         seed_q  <= 1'b0;
         cap_q   <= 1'b0;
         pipe_q  <= 1'b0;
         dfft_q  <= FFT_8K;
         dsa_q   <= 1'b1;
         dgi_q   <= 3'h0;
         step_q  <= PILOT_STEP_DENSE;
      end else begin
         state_q <= st_q;
         acq_q   <= (st_q == ST_RUN);
         sync_q  <= (st_q == ST_SEARCH);
         seed_q  <= (st_q == ST_SEARCH) && zap_q && seed_from_store;
         cap_q   <= (st_q == ST_CAPTURE);
         pipe_q  <= (st_q == ST_RUN) && !ext_act_q;
         // Only these three steer preamble decode
         dfft_q  <= prm.fft_size;
         dsa_q   <= prm.single_antenna_mode;
         dgi_q   <= prm.guard_interval;
         step_q  <= step_d;
      end
   end

   assign state_out             = state_q;
   assign no_signal             = nosig_q;
   assign acquired              = acq_q;
   assign run_sync              = sync_q;
   assign use_seed              = seed_q;
   assign capture_enable        = cap_q;
   assign decode_start          = dstart_q;
   assign dec_fft_size          = dfft_q;
   assign dec_single_antenna    = dsa_q;
   assign dec_guard_interval    = dgi_q;
   assign pilot_step            = step_q;
   assign extended_carriers     = ext_q;
   assign frame_position        = fidx_q;
   assign extension_part_active = ext_act_q;
   assign pipe_enable           = pipe_q;
   assign pipe_cells_load       = cells_q;
endmodule
`default_nettype wire

// ===== verification/acq_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module acq_seq_asserts
   import acq_pkg::*;
#(
   parameter longint unsigned NO_SIGNAL_CYCLES = NO_SIGNAL_CYC
)(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       start_scan,
   input wire logic       symbol_strobe,
   input wire logic       decode_done,
   input wire logic       decode_ok,
   input wire logic [2:0] sig_guard_interval,
   input wire logic [3:0] state_out,
   input wire logic       no_signal,
   input wire logic       run_sync,
   input wire logic       decode_start,
   input wire logic [2:0] dec_fft_size,
   input wire logic       dec_single_antenna,
   input wire logic [2:0] dec_guard_interval,
   input wire logic [3:0] pilot_step
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // -------------
   // Search dwell
   // -------------
   logic [31:0] dwell_q;
   logic [31:0] dwell_d;
   always_comb begin
      dwell_d = dwell_q + 32'h1;
      if (state_out != 4'(ST_SEARCH)) begin
         dwell_d = 32'h0;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dwell_q <= 32'h0;
      end else begin
         dwell_q <= dwell_d;
      end
   end
   // -------------
   // Properties
   // -------------
   strobe_then_start_a: assert property (
      decode_start |-> $past(symbol_strobe) || $past(symbol_strobe, 2))
      else $error("decode start without a symbol before it");
   start_pulse_a: assert property (
      decode_start |=> !decode_start)
      else $error("decode start longer than one cycle");
   pilot_spacing_a: assert property (
      $stable(dec_fft_size) && $stable(dec_single_antenna) |-> pilot_step ==
      ((dec_fft_size == FFT_32K && dec_single_antenna) ? 4'h6 : 4'h3))
      else $error("pilot spacing wrong");
   fail_restart_a: assert property (
      decode_done && !decode_ok && state_out == 4'(ST_DECODE) |-> ##[1:5] run_sync)
      else $error("no restart after failed decode");
   verify_restart_a: assert property (
      decode_done && decode_ok && state_out == 4'(ST_DECODE) &&
      sig_guard_interval != dec_guard_interval |-> ##[1:6] run_sync)
      else $error("no restart after parameter mismatch");
   dwell_floor_a: assert property (
      $rose(no_signal) |-> dwell_q >= NO_SIGNAL_CYCLES - 3)
      else $error("no signal declared too early");
   dwell_limit_a: assert property (
      state_out == 4'(ST_SEARCH) |-> dwell_q <= NO_SIGNAL_CYCLES + 2)
      else $error("search outlived its limit");
   no_signal_hold_a: assert property (
      no_signal && !start_scan |=> no_signal)
      else $error("no signal flag dropped");
endmodule
bind acq_seq acq_seq_asserts #(.NO_SIGNAL_CYCLES(NO_SIGNAL_CYCLES)) chk_u (.*);
`default_nettype wire

// ===== verification/tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module tx_model (
   input  wire logic       clk_sys,
   input  wire logic       go,
   input  wire logic       ext,
   input  wire logic [4:0] count,
   output logic            preamble_seen,
   output logic            preamble_is_extension,
   output logic            symbol_strobe,
   output logic [7:0]      current_frame_index
);
   initial begin
      {preamble_seen, preamble_is_extension, symbol_strobe} = '0;
      current_frame_index = 8'hff;
   end
   // -------------
   // Frame per go
   // -------------
   always @(posedge clk_sys) begin
      if (go) begin
         #1;
         preamble_seen = 1'b1;
         preamble_is_extension = ext;
         if (!ext) begin
            current_frame_index = current_frame_index + 8'h01;
         end
         @(posedge clk_sys);
         #1;
         preamble_seen = 1'b0;
         // Padding and reserved tones carry no data, so only count shows
         repeat (ext ? 5'h0 : count) begin
            symbol_strobe = 1'b1;
            @(posedge clk_sys);
            #1;
         end
         symbol_strobe = 1'b0;
      end else begin
         // Qualifier is meaningless between preambles, toggle it each cycle without go; it sits while symbols are sent
         #1;
         preamble_is_extension = ~preamble_is_extension;
      end
   end
endmodule
`default_nettype wire

// ===== verification/acq_seq_test.sv
`timescale 1ns/1ps
`default_nettype none
module acq_seq_test import acq_pkg::*;;
   localparam logic [4:0] NSYM [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h01};
   logic       clk_sys, rst, start_scan, start_zap, tuner_settled, seed_from_store;
   logic       sync_done, preamble_seen, preamble_is_extension, symbol_strobe, decode_done;
   logic       decode_ok, det_single_antenna, sig_single_antenna, sig_extended_carriers;
   logic       interleaving_type, cells_valid, go, ext, no_signal, acquired, run_sync;
   logic       use_seed, capture_enable, decode_start, dec_single_antenna, pipe_enable;
   logic       extended_carriers, extension_part_active, pipe_cells_load;
   logic [2:0] det_fft_size, det_guard_interval, sig_fft_size, sig_guard_interval;
   logic [2:0] dec_fft_size, dec_guard_interval;
   logic [3:0] state_out, pilot_step;
   logic [4:0] count;
   logic [7:0] current_frame_index, extension_part_interval, extension_part_length;
   logic [7:0] pipe_frame_interval, pipe_first_frame_index, interleaving_length, frame_position;
   int         bad_count = 0;
   int         n_compared = 0;

   acq_seq #(.NO_SIGNAL_CYCLES(50)) dut_u (.*);
   tx_model tx_u (.*);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // -------------
   // Helpers
   // -------------
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_st(input acq_state_e s);
      int n;
      n = 0;
      while (state_out !== 4'(s) && n < 100) begin
         step(1);
         n++;
      end
      chk(8'(n < 100), 8'h01);
   endtask
   task automatic restart();
      rst = 1'b1;
      step(2);
      chk({dec_fft_size, dec_single_antenna, pilot_step}, {FFT_8K, 1'b1, 4'h3});
      rst = 1'b0;
      step(1);
   endtask
   task automatic frame(input logic e);
      ext = e;
      go = 1'b1;
      step(1);
      go = 1'b0;
      step(20);
   endtask
   task automatic wait_acq(output int k);
      k = 0;
      while (acquired !== 1'b1 && k < 8) begin
         frame(1'b0);
         k++;
      end
      chk(8'(acquired), 8'h01);
   endtask
   // Decode start may only follow the whole symbol group
   task automatic acquire(input logic [4:0] nsym, input logic ok);
      int n;
      n = 0;
      count = nsym;
      frame_go: begin
         ext = 1'b0;
         go = 1'b1;
         step(1);
         go = 1'b0;
      end
      while (decode_start !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      chk(8'(n >= int'(nsym) + 1 && n <= int'(nsym) + 2), 8'h01);
      chk(8'(capture_enable), 8'h01);
      step(2);
      decode_ok = ok;
      decode_done = 1'b1;
      step(1);
      decode_done = 1'b0;
   endtask
   // -------------
   // Scenarios
   // -------------
   task automatic scan(input logic [2:0] f, input logic s, input logic e,
                       input logic [2:0] gs, input logic ok);
      int k;
      {det_fft_size, det_single_antenna, sig_fft_size, sig_single_antenna} = {f, s, f, s};
      {sig_guard_interval, sig_extended_carriers} = {gs, e};
      start_scan = 1'b1;
      step(1);
      start_scan = 1'b0;
      wait_st(ST_SEARCH);
      acquire(NSYM[f], ok);
      chk({dec_fft_size, dec_single_antenna, dec_guard_interval}, {1'b0, f, s, 3'h2});
      chk(8'(pilot_step), (f == FFT_32K && s) ? 8'h06 : 8'h03);
      if (ok && gs == 3'h2) begin
         wait_acq(k);
         chk(8'(k <= 1), 8'h01);
         chk(8'(extended_carriers), 8'(e));
         chk(frame_position, current_frame_index);
      end else begin
         step(4);
         chk(8'(run_sync), 8'h01);
         step(60);
         chk(8'(no_signal), 8'h01);
      end
   endtask
   task automatic ext_part();
      logic [7:0] fp;
      fp = frame_position;
      ext = 1'b1;
      go = 1'b1;
      step(1);
      go = 1'b0;
      step(3);
      chk(8'(extension_part_active), 8'h01);
      step(17);
      chk(8'(extension_part_active), 8'h00);
      frame(1'b0);
      chk(8'(extension_part_active), 8'h00);
      chk(frame_position, fp + 8'h01);
   endtask
   task automatic zap();
      int k;
      start_zap = 1'b1;
      step(1);
      start_zap = 1'b0;
      wait_st(ST_RETUNE);
      {sync_done, seed_from_store, interleaving_type, tuner_settled} = 4'b0111;
      det_fft_size = FFT_1K;
      wait_st(ST_SEARCH);
      tuner_settled = 1'b0;
      chk(8'(use_seed), 8'h01);
      acquire(NSYM[FFT_8K], 1'b1);
      chk(8'(dec_fft_size), 8'(FFT_8K));
      wait_acq(k);
      chk({pipe_enable, frame_position[0]}, 8'h02);
      cells_valid = 1'b1;
      step(2);
      chk(8'(pipe_cells_load), 8'h01);
      cells_valid = 1'b0;
   endtask
   task automatic summarize();
      if (bad_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Run needs under a thousand cycles; this limit of 25000 cycles is far beyond that
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
   initial begin
      {start_scan, start_zap, tuner_settled, seed_from_store, decode_done, decode_ok} = '0;
      {sig_extended_carriers, interleaving_type, cells_valid, go, ext, count} = '0;
      {det_fft_size, det_single_antenna, sig_fft_size, sig_single_antenna} = '0;
      {pipe_first_frame_index, interleaving_length} = {8'h00, 8'h02};
      {extension_part_interval, extension_part_length, pipe_frame_interval} = {8'h01, 8'h10, 8'h01};
      {rst, sync_done, det_guard_interval, sig_guard_interval} = {2'b11, 3'h2, 3'h2};
      step(18);
      restart();
      for (int i = 0; i < 6; i++) begin
         scan(3'(i), i[0], i[1], 3'h2, 1'b1);
         restart();
      end
      scan(FFT_8K, 1'b1, 1'b0, 3'h5, 1'b1);
      scan(FFT_4K, 1'b0, 1'b0, 3'h2, 1'b0);
      scan(FFT_8K, 1'b1, 1'b0, 3'h2, 1'b1);
      ext_part();
      zap();
      summarize();
   end
endmodule
`default_nettype wire
